// *** include/uart_pkg.sv ***
package uart_pkg;
  // ========================================
  // register offsets
  localparam logic [11:0] DATA_OFS = 12'h000;
  localparam logic [11:0] FLAG_OFS = 12'h018;
  localparam logic [11:0] IBRD_OFS = 12'h024;
  localparam logic [11:0] FBRD_OFS = 12'h028;
  localparam logic [11:0] LCRH_OFS = 12'h02C;
  localparam logic [11:0] CTL_OFS  = 12'h030;
  // ========================================
  // fields and reset values
  localparam logic [15:0] CTL_RESET   = 16'h0300;
  localparam int          CTL_EN_BIT  = 0;
  localparam int          CTL_TXE_BIT = 8;
  localparam int          CTL_RXE_BIT = 9;
  localparam logic [29:0] WORK_RESET  = 30'h0000_0000;
  // ========================================
  // queues and timing
  localparam int          QDEPTH      = 16;
  localparam logic [4:0]  QLIM_ON     = 5'h10;
  localparam logic [4:0]  QLIM_OFF    = 5'h01;
  localparam logic [3:0]  START_TICK  = 4'h7;
  localparam logic [3:0]  BIT_TICK    = 4'hF;
  localparam logic [22:0] OVS_STEP    = 23'h00_0040;
  localparam logic [21:0] DIV_MIN     = 22'h00_0040;
  // ========================================
  // types
  typedef enum logic [4:0]
  {
    LS_IDLE  = 5'b00001,
    LS_START = 5'b00010,
    LS_DATA  = 5'b00100,
    LS_PAR   = 5'b01000,
    LS_STOP  = 5'b10000
  } line_state_t;
  typedef struct packed
  {
    logic       sps;
    logic [1:0] wlen;
    logic       queue_enable_bit;
    logic       stp2;
    logic       eps;
    logic       pen;
    logic       brk;
  } line_cfg_t;
  typedef struct packed
  {
    logic       oe;
    logic       be;
    logic       pe;
    logic       fe;
    logic [7:0] data;
  } rx_entry_t;
endpackage

// *** core/uart_txrx_baud_core.sv ***
`timescale 1ns/1ps
//
// Contract
// - reset leaves transmit and receive enabled
// - disable finishes the character in flight
// - start, data lsb first, parity, stops
// - check overrun, parity, framing, break per character
// - two sixteen-entry queues, receive adds four flags
// - divisor is 16-bit integer plus 6-bit fraction
// - oversample tick at sixteen times baud
// - divisor and format load on line-control write
// - enabled unit sends queued characters back to back
// - busy while queued or shifting, even disabled
// - start accepted only if low at eighth tick
// - data bits sampled every sixteenth tick
// - parity bit sampled and checked when enabled
// - low stop bit flags framing error
// - data plus flags pushed as one entry
// - five to eight bits, parities, one/two stops
// - queues one deep until queue enable set
module uart_txrx_baud_core
  import uart_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        port0_serial_in,
  output logic             port0_serial_out
);

  // ========================================
  // helpers
  function automatic logic [7:0] len_mask(input logic [1:0] wlen);
    len_mask = 8'hFF >> (3'd3 - {1'b0, wlen});
  endfunction

  function automatic logic [7:0] rx_align(input logic [7:0] shr,
                                          input logic [1:0] wlen);
    rx_align = shr >> (3'd3 - {1'b0, wlen});
  endfunction

  // even gives xor of data, odd its inverse, stick a fixed level
  function automatic logic parity_of(input logic [7:0] d,
                                     input line_cfg_t  c);
    parity_of = c.sps ? ~c.eps : (^d) ^ ~c.eps;
  endfunction

  // ========================================
  // registers and apb
  logic        [15:0] ctl_reg;
  logic        [15:0] ibrd_reg;
  logic        [5:0]  fbrd_reg;
  logic        [29:0] work_reg;
  logic        [31:0] prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  logic               busy_reg;
  line_cfg_t          cfg;
  logic        [21:0] divisor;
  logic        [31:0] rd_data;
  logic        [7:0]  flags;
  logic               setup_acc;
  logic               wr_en;
  logic               sel_data;
  logic               sel_flag;
  logic               sel_ibrd;
  logic               sel_fbrd;
  logic               sel_lcrh;
  logic               sel_ctl;
  logic               addr_ok;

  assign cfg       = line_cfg_t'(work_reg[7:0]);
  assign divisor   = work_reg[29:8];
  assign setup_acc = psel & penable & ~pready_reg;
  assign wr_en     = psel & penable & pready_reg & pwrite;
  assign sel_data  = paddr == DATA_OFS;
  assign sel_flag  = paddr == FLAG_OFS;
  assign sel_ibrd  = paddr == IBRD_OFS;
  assign sel_fbrd  = paddr == FBRD_OFS;
  assign sel_lcrh  = paddr == LCRH_OFS;
  assign sel_ctl   = paddr == CTL_OFS;
  assign addr_ok   = sel_data | sel_flag | sel_ibrd | sel_fbrd
                   | sel_lcrh | sel_ctl;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_reg  <= CTL_RESET;
      ibrd_reg <= 16'h0000;
      fbrd_reg <= 6'h00;
      work_reg <= WORK_RESET;
    end
    else
    begin
      if (wr_en & sel_ctl)
        ctl_reg <= pwdata[15:0];
      if (wr_en & sel_ibrd)
        ibrd_reg <= pwdata[15:0];
      if (wr_en & sel_fbrd)
        fbrd_reg <= pwdata[5:0];
      // divisor shadows only reach the generator here
      if (wr_en & sel_lcrh)
        work_reg <= {ibrd_reg, fbrd_reg, pwdata[7:0]};
    end
  end

  // one wait state: answer rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= setup_acc;
      pslverr_reg <= setup_acc & ~addr_ok;
      if (setup_acc & ~pwrite)
        prdata_reg <= rd_data;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ========================================
  // queues
  logic        [7:0]  tx_mem [QDEPTH];
  rx_entry_t          rx_mem [QDEPTH];
  logic        [3:0]  tx_wp;
  logic        [3:0]  tx_rp;
  logic        [3:0]  rx_wp;
  logic        [3:0]  rx_rp;
  logic        [4:0]  tx_cnt;
  logic        [4:0]  rx_cnt;
  logic        [4:0]  q_lim;
  logic               tx_full;
  logic               tx_empty;
  logic               rx_full;
  logic               rx_empty;
  logic               tx_push;
  logic               tx_pop;
  logic               rx_push;
  logic               rx_pop;
  logic               ovr_pend;
  rx_entry_t          rx_ent;

  assign q_lim    = cfg.queue_enable_bit ? QLIM_ON : QLIM_OFF;
  assign tx_full  = tx_cnt >= q_lim;
  assign rx_full  = rx_cnt >= q_lim;
  assign tx_empty = tx_cnt == 5'h00;
  assign rx_empty = rx_cnt == 5'h00;
  assign tx_push  = wr_en & sel_data & ~tx_full;
  // pop at capture so the entry read is the entry removed
  assign rx_pop   = setup_acc & ~pwrite & sel_data & ~rx_empty;
  assign flags    = {~tx_cnt[4] & tx_empty, rx_full, tx_full,
                     rx_empty, busy_reg, 3'b000};
  assign rd_data  = sel_data ? {20'h0_0000, rx_mem[rx_rp]}
                  : sel_flag ? {24'h00_0000, flags}
                  : sel_ibrd ? {16'h0000, ibrd_reg}
                  : sel_fbrd ? {26'h000_0000, fbrd_reg}
                  : sel_lcrh ? {24'h00_0000, work_reg[7:0]}
                  : sel_ctl  ? {16'h0000, ctl_reg}
                  : 32'h0000_0000;

  always_ff @(posedge pclk)
  begin
    if (tx_push)
      tx_mem[tx_wp] <= pwdata[7:0];
    if (rx_push & ~rx_full)
      rx_mem[rx_wp] <= rx_ent;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp    <= 4'h0;
      tx_rp    <= 4'h0;
      rx_wp    <= 4'h0;
      rx_rp    <= 4'h0;
      tx_cnt   <= 5'h00;
      rx_cnt   <= 5'h00;
      ovr_pend <= 1'b0;
    end
    else
    begin
      tx_wp  <= tx_wp + 4'(tx_push);
      tx_rp  <= tx_rp + 4'(tx_pop);
      tx_cnt <= tx_cnt + 5'(tx_push) - 5'(tx_pop);
      rx_wp  <= rx_wp + 4'(rx_push & ~rx_full);
      rx_rp  <= rx_rp + 4'(rx_pop);
      rx_cnt <= rx_cnt + 5'(rx_push & ~rx_full) - 5'(rx_pop);
      // a lost character marks the next one stored
      if (rx_push)
        ovr_pend <= rx_full;
    end
  end

  // ========================================
  // oversample tick
  logic        [22:0] acc_reg;
  logic        [22:0] acc_sum;
  logic               div_ok;
  logic               tick_next;
  logic               ovs_tick;

  assign acc_sum   = acc_reg + OVS_STEP;
  assign div_ok    = divisor >= DIV_MIN;
  assign tick_next = div_ok & (acc_sum >= {1'b0, divisor});

  // divisor in 1/64 units, so one tick per divisor clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg  <= 23'h00_0000;
      ovs_tick <= 1'b0;
    end
    else
    begin
      acc_reg  <= !div_ok ? 23'h00_0000
                : tick_next ? acc_sum - {1'b0, divisor}
                : acc_sum;
      ovs_tick <= tick_next;
    end
  end

  // ========================================
  // transmitter
  line_state_t        tx_state;
  logic        [3:0]  tx_tcnt;
  logic        [2:0]  tx_bcnt;
  logic        [7:0]  tx_shr;
  logic        [7:0]  tx_head;
  logic               tx_par;
  logic               tx_go;
  logic               tx_line;
  logic               out_reg;
  logic        [2:0]  last_bit;

  assign last_bit = {1'b1, cfg.wlen};
  assign tx_head  = tx_mem[tx_rp] & len_mask(cfg.wlen);
  // new characters only start while enabled
  assign tx_go    = (tx_state == LS_IDLE) & ovs_tick & ~tx_empty
                  & ctl_reg[CTL_EN_BIT] & ctl_reg[CTL_TXE_BIT];
  assign tx_pop   = tx_go;
  assign tx_line  = ~cfg.brk & ((tx_state == LS_START) ? 1'b0
                  : (tx_state == LS_DATA) ? tx_shr[0]
                  : (tx_state == LS_PAR) ? tx_par : 1'b1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= LS_IDLE;
      tx_tcnt  <= 4'h0;
      tx_bcnt  <= 3'h0;
      tx_shr   <= 8'h00;
      tx_par   <= 1'b0;
    end
    else if (tx_go)
    begin
      tx_state <= LS_START;
      tx_tcnt  <= 4'h0;
      tx_shr   <= tx_head;
      tx_par   <= parity_of(tx_head, cfg);
    end
    else if (ovs_tick & (tx_state != LS_IDLE))
    begin
      // once started a frame runs out regardless of enable
      tx_tcnt <= tx_tcnt + 4'h1;
      if (tx_tcnt == BIT_TICK)
      begin
        case (tx_state)
          LS_START:
          begin
            tx_state <= LS_DATA;
            tx_bcnt  <= 3'h0;
          end
          LS_DATA:
          begin
            tx_shr  <= tx_shr >> 1;
            tx_bcnt <= tx_bcnt + 3'h1;
            if (tx_bcnt == last_bit)
            begin
              tx_state <= cfg.pen ? LS_PAR : LS_STOP;
              tx_bcnt  <= 3'h0;
            end
          end
          LS_PAR:
            tx_state <= LS_STOP;
          LS_STOP:
          begin
            tx_bcnt <= 3'h1;
            if (!(cfg.stp2 && tx_bcnt == 3'h0))
              tx_state <= LS_IDLE;
          end
          default:
            tx_state <= LS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_reg  <= 1'b1;
      busy_reg <= 1'b0;
    end
    else
    begin
      out_reg  <= tx_line;
      busy_reg <= ~tx_empty | tx_push | (tx_state != LS_IDLE);
    end
  end

  assign port0_serial_out = out_reg;

  // ========================================
  // receiver
  line_state_t        rx_state;
  logic               rx_meta;
  logic               rx_sync;
  logic               rx_armed;
  logic        [3:0]  rx_tcnt;
  logic        [2:0]  rx_bcnt;
  logic        [7:0]  rx_shr;
  logic               rx_pe;
  logic               rx_zero;
  logic               rx_go;
  logic               rx_bit_end;

  // armed only after a high level, so a held break is one character
  assign rx_go      = (rx_state == LS_IDLE) & rx_armed & ~rx_sync
                    & ctl_reg[CTL_EN_BIT] & ctl_reg[CTL_RXE_BIT];
  assign rx_bit_end = ovs_tick & (rx_tcnt == BIT_TICK);
  assign rx_push    = (rx_state == LS_STOP) & rx_bit_end;
  assign rx_ent     = '{oe: ovr_pend,
                        be: rx_zero & ~rx_sync,
                        pe: cfg.pen & rx_pe,
                        fe: ~rx_sync,
                        data: rx_align(rx_shr, cfg.wlen)};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= port0_serial_in;
      rx_sync <= rx_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= LS_IDLE;
      rx_armed <= 1'b0;
      rx_tcnt  <= 4'h0;
      rx_bcnt  <= 3'h0;
      rx_shr   <= 8'h00;
      rx_pe    <= 1'b0;
      rx_zero  <= 1'b0;
    end
    else if (rx_go)
    begin
      rx_state <= LS_START;
      rx_armed <= 1'b0;
      rx_tcnt  <= 4'h0;
    end
    else if (rx_state == LS_IDLE)
      rx_armed <= rx_armed | rx_sync;
    else if (ovs_tick)
    begin
      rx_tcnt <= rx_tcnt + 4'h1;
      case (rx_state)
        LS_START:
          if (rx_tcnt == START_TICK)
          begin
            rx_state <= rx_sync ? LS_IDLE : LS_DATA;
            rx_tcnt  <= 4'h0;
            rx_bcnt  <= 3'h0;
            rx_pe    <= 1'b0;
            rx_zero  <= 1'b1;
          end
        LS_DATA:
          if (rx_tcnt == BIT_TICK)
          begin
            rx_shr  <= {rx_sync, rx_shr[7:1]};
            rx_zero <= rx_zero & ~rx_sync;
            rx_bcnt <= rx_bcnt + 3'h1;
            if (rx_bcnt == last_bit)
              rx_state <= cfg.pen ? LS_PAR : LS_STOP;
          end
        LS_PAR:
          if (rx_tcnt == BIT_TICK)
          begin
            rx_pe    <= rx_sync !=
                        parity_of(rx_align(rx_shr, cfg.wlen), cfg);
            rx_zero  <= rx_zero & ~rx_sync;
            rx_state <= LS_STOP;
          end
        LS_STOP:
          if (rx_tcnt == BIT_TICK)
            rx_state <= LS_IDLE;
        default:
          rx_state <= LS_IDLE;
      endcase
    end
  end

  // ========================================
  // checks
  reset_enables_a:
    assert property (@(posedge pclk) $rose(presetn)
      |-> ctl_reg[CTL_TXE_BIT] && ctl_reg[CTL_RXE_BIT])
    else $error("enables not set after reset");
  frame_finish_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      tx_state == LS_DATA && !ctl_reg[CTL_EN_BIT] |=> tx_state != LS_IDLE)
    else $error("frame cut short by disable");
  start_low_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      tx_state == LS_START |=> !port0_serial_out)
    else $error("start bit not low");
  divisor_load_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      $changed(work_reg) |-> $past(wr_en) && $past(sel_lcrh))
    else $error("working register changed without line write");
  busy_rise_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      !tx_empty |=> busy_reg)
    else $error("busy low with queued data");
  start_reject_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      rx_state == LS_START && ovs_tick && rx_tcnt == START_TICK && rx_sync
      |=> rx_state == LS_IDLE)
    else $error("false start accepted");
  frame_err_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      rx_push && !rx_full |=> rx_mem[$past(rx_wp)].fe == !$past(rx_sync))
    else $error("framing flag wrong");
  queue_bound_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      tx_cnt <= QLIM_ON && rx_cnt <= QLIM_ON)
    else $error("queue count above depth");

endmodule

// *** dv/serial_far_end.sv ***
`timescale 1ns/1ps
// ========================================
// remote serial device, bit time counted in pclk cycles
module serial_far_end #(
  parameter int BIT_CLKS = 40
) (
  // clock
  input  wire logic pclk,
  // serial lines
  input  wire logic line_from_dut,
  output logic      line_to_dut
);
  // idle level is high, as on a pulled-up line
  initial line_to_dut = 1'b1;

  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      line_to_dut <= f[i];
      repeat (BIT_CLKS - 1) @(posedge pclk);
    end
    @(posedge pclk);
    line_to_dut <= 1'b1;
  endtask

  // short low pulse, too short to be a start bit
  task automatic blip(input int c);
    @(posedge pclk);
    line_to_dut <= 1'b0;
    repeat (c) @(posedge pclk);
    line_to_dut <= 1'b1;
  endtask

  // samples mid-bit and returns inside the last bit, so a
  // start edge that follows back to back is not missed
  task automatic grab(output logic [11:0] f, input int n);
    f = 12'hFFF;
    @(negedge line_from_dut);
    for (int i = 0; i < n; i++)
    begin
      repeat (i == 0 ? BIT_CLKS / 2 : BIT_CLKS) @(posedge pclk);
      f[i] = line_from_dut;
    end
  endtask
endmodule

// *** dv/uart_txrx_baud_core_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value %s: expected %h, seen %h", n, e, g); \
    end \
  end
module uart_txrx_baud_core_tb_top;
  import uart_pkg::*;
  // ========================================
  // signals
  localparam int BITC = 40;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ser_in;
  logic        ser_out;
  logic        last_err;
  logic [31:0] r;
  logic [11:0] f;
  logic [11:0] ef;
  logic [7:0]  lc;
  logic [7:0]  d;
  logic [7:0]  fmts [7] = '{8'h70, 8'h16, 8'h3A, 8'h5E, 8'hF2, 8'hF6, 8'h60};
  int          n;
  int          m;
  int          bad_count;
  int          comparisons;

  uart_txrx_baud_core i_dut (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .port0_serial_in  (ser_in),
    .port0_serial_out (ser_out)
  );

  serial_far_end #(.BIT_CLKS(BITC)) i_far (
    .pclk          (pclk),
    .line_from_dut (ser_out),
    .line_to_dut   (ser_in)
  );

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ========================================
  // bus and frame helpers
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd_v);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_v     = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    apb(1'b1, a, wd, dummy);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] rd_v);
    apb(1'b0, a, 32'h0000_0000, rd_v);
  endtask

  // unit is disabled around every reprogramming
  task automatic cfg(input logic [7:0] l);
    wr(CTL_OFS, 32'h0000_0300);
    wr(LCRH_OFS, {24'h0, l});
    wr(CTL_OFS, 32'h0000_0301);
  endtask

  function automatic logic [11:0] frame(input logic [7:0] dd,
                                        input logic [7:0] l,
                                        output int nb);
    logic [11:0] fr;
    int          w;
    fr = 12'hFFE;
    w  = 5 + int'(l[6:5]);
    for (int i = 0; i < w; i++)
      fr[1 + i] = dd[i];
    nb = 1 + w;
    // stick parity forces a level, else even or odd over data
    if (l[1])
    begin
      fr[nb] = l[7] ? ~l[2] : ~l[2] ^ (^(dd & (8'hFF >> (8 - w))));
      nb++;
    end
    nb = nb + (l[3] ? 2 : 1);
    return fr;
  endfunction

  task automatic tx_far(input logic [7:0] dd, input logic [7:0] l);
    ef = frame(dd, l, n);
    i_far.send(ef, n);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end

  // ========================================
  // tests
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL_OFS, r);
    `CHK("control", 32'h0000_0300, r);
    `CHK("idle line", 1'b1, ser_out);
    rd(FLAG_OFS, r);
    `CHK("flags", 32'h0000_0090, r);
    rd(12'h004, r);
    `CHK("unmapped err", 1'b1, last_err);
    `CHK("unmapped data", 32'h0000_0000, r);
    $display("test reset done");

    // 2.5 clocks per tick, so one bit is 40 clocks
    wr(IBRD_OFS, 32'h0000_0002);
    wr(FBRD_OFS, 32'h0000_0020);
    for (int i = 0; i < 7; i++)
    begin
      lc = fmts[i];
      d = 8'h35 + 8'(i * 75);
      ef = frame(d, lc, n);
      cfg(lc);
      rd(LCRH_OFS, r);
      `CHK("line control", {24'h0, lc}, r);
      fork
        i_far.grab(f, n);
        begin
          wr(DATA_OFS, {24'h0, d});
          rd(FLAG_OFS, r);
        end
      join
      `CHK("busy", 1'b1, r[3]);
      `CHK("tx frame", ef, f);
      repeat (BITC) @(posedge pclk);
      rd(FLAG_OFS, r);
      `CHK("idle flags", 32'h0000_0090, r);
      i_far.send(ef, n);
      rd(DATA_OFS, r);
      d = d & (8'hFF >> (2'd3 - lc[6:5]));
      `CHK("rx entry", {24'h0, d}, r);
    end
    $display("test formats done");

    i_far.blip(6);
    repeat (BITC * 12) @(posedge pclk);
    rd(FLAG_OFS, r);
    `CHK("rx empty", 1'b1, r[4]);
    tx_far(8'h11, 8'h60);
    tx_far(8'h22, 8'h60);
    rd(DATA_OFS, r);
    `CHK("held entry", 32'h0000_0011, r);
    tx_far(8'h33, 8'h60);
    rd(DATA_OFS, r);
    `CHK("overrun entry", 32'h0000_0833, r);
    $display("test overrun done");

    cfg(8'h72);
    ef = frame(8'hC3, 8'h72, n);
    i_far.send(ef ^ 12'h200, n);
    rd(DATA_OFS, r);
    `CHK("parity entry", 32'h0000_02C3, r);
    i_far.send(ef ^ 12'h400, n);
    rd(DATA_OFS, r);
    `CHK("framing entry", 32'h0000_01C3, r);
    i_far.send(12'h000, n);
    rd(DATA_OFS, r);
    `CHK("break flag", 1'b1, r[10]);
    `CHK("break data", 8'h00, r[7:0]);
    // break-setting bit holds the transmit line low
    cfg(8'h73);
    repeat (4) @(posedge pclk);
    `CHK("break line", 1'b0, ser_out);
    $display("test rx errors done");

    for (int k = 0; k < 2; k++)
    begin
      lc = k ? 8'h70 : 8'h60;
      m = k ? 16 : 1;
      wr(CTL_OFS, 32'h0000_0300);
      wr(LCRH_OFS, {24'h0, lc});
      for (int j = 0; j < m; j++)
        wr(DATA_OFS, 32'h0000_0040 + j);
      rd(FLAG_OFS, r);
      `CHK("tx full", 1'b1, r[5]);
      wr(DATA_OFS, 32'h0000_00EE);
      fork
        for (int j = 0; j < m; j++)
        begin
          i_far.grab(f, 10);
          `CHK("queued frame", {3'b111, 8'(64 + j), 1'b0}, f);
        end
        wr(CTL_OFS, 32'h0000_0301);
      join
      repeat (BITC) @(posedge pclk);
      rd(FLAG_OFS, r);
      `CHK("drained", 32'h0000_0090, r);
    end
    $display("test queues done");

    // new divisor must wait for a line control write
    wr(CTL_OFS, 32'h0000_0300);
    wr(IBRD_OFS, 32'h0000_0004);
    wr(CTL_OFS, 32'h0000_0301);
    fork
      i_far.grab(f, 10);
      begin
        wr(DATA_OFS, 32'h0000_005A);
        repeat (100) @(posedge pclk);
        wr(CTL_OFS, 32'h0000_0300);
        rd(FLAG_OFS, r);
      end
    join
    `CHK("busy disabled", 1'b1, r[3]);
    `CHK("finished frame", 12'hEB4, f);
    repeat (BITC) @(posedge pclk);
    rd(FLAG_OFS, r);
    `CHK("busy cleared", 1'b0, r[3]);
    $display("test disable done");
    tally_and_finish();
  end
endmodule
